// ==== wip_port.sv ====
/*
 * Write-only two-wire slave port: receives slave address, register address and
 * data bytes, acknowledges them and hands register writes to the system domain.
 * Assumes SCL and SDA arrive asynchronously and are oversampled by link_clk,
 * which runs free; SDA is an open-drain wire resolved outside.
 */
// Overview of operation
// - only writes accepted; read bit must be zero
// - match seven-bit address, upper five fixed
// - strap connection sets address bits two, one
// - SDA falling, SCL high: start, receive address
// - SDA rising, SCL high: stop, wait start
// - sample SDA on stable high SCL
// - acknowledge matched address through ninth pulse
// - register address byte acknowledged
// - data byte acknowledged and passed on
// - SCL is input only, no stretching
// - SDA driven open-drain only
// - pointer increments on each data acknowledge
// - low shutdown pin forces chip shutdown
`timescale 1ns/1ps
module wip_port import wip_pkg::*; (
    // system clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // link clock
    input  wire logic       link_clk,
    // two-wire bus
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // strap and shutdown pins
    input  wire logic [1:0] strap_conn,
    input  wire logic       shutdown_n_pin,
    // register write output
    output logic            reg_wr_valid,
    output logic      [7:0] reg_wr_addr,
    output logic      [7:0] reg_wr_data,
    output logic            chip_shutdown
);
    logic             link_rst_meta;
    logic             link_rst_n;
    logic             link_rst;
    logic             sys_rst;
    logic             scl_meta;
    logic             scl_s;
    logic             scl_q;
    logic             sda_meta;
    logic             sda_s;
    logic             sda_q;
    logic       [1:0] strap_meta;
    logic       [1:0] strap_s;
    logic             strap_done;
    logic       [1:0] addr_low;
    logic             sdn_meta;
    logic             sdn_s;
    wip_state_t       state;
    wip_kind_t        kind;
    logic       [2:0] bit_cnt;
    logic       [7:0] shift;
    logic       [7:0] pointer;
    logic       [7:0] data_byte;
    logic             ack_pend;
    logic             drive_low;
    logic             send_word;
    logic       [7:0] rx_byte;
    logic             scl_rise;
    logic             scl_fall;
    logic             start_seen;
    logic             stop_seen;

    function automatic logic [1:0] strap_bits(input logic [1:0] conn);
        unique case (wip_strap_t'(conn))
            WIP_STRAP_GND: strap_bits = WIP_AD_GND;
            WIP_STRAP_VCC: strap_bits = WIP_AD_VCC;
            WIP_STRAP_SCL: strap_bits = WIP_AD_SCL;
            WIP_STRAP_SDA: strap_bits = WIP_AD_SDA;
        endcase
    endfunction

    assign sys_rst  = ~resetn;
    assign link_rst = ~link_rst_n;

    // reset brought into the link domain
    always_ff @(posedge link_clk) begin
        link_rst_meta <= resetn;
        link_rst_n    <= link_rst_meta;
    end

    // pin synchronisers
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            scl_meta   <= 1'b1;
            scl_s      <= 1'b1;
            scl_q      <= 1'b1;
            sda_meta   <= 1'b1;
            sda_s      <= 1'b1;
            sda_q      <= 1'b1;
        end else begin
            scl_meta   <= scl_in;
            scl_s      <= scl_meta;
            scl_q      <= scl_s;
            sda_meta   <= sda_in;
            sda_s      <= sda_meta;
            sda_q      <= sda_s;
        end
    end

    // strap synchroniser runs through reset, so it holds the pin level at release
    always_ff @(posedge link_clk) begin
        strap_meta <= strap_conn;
        strap_s    <= strap_meta;
    end

    // strap caught once after reset release
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            strap_done <= 1'b0;
            addr_low   <= WIP_AD_GND;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            addr_low   <= strap_bits(strap_s);
        end
    end

    // sample on the rising edge, so SDA is taken in the stable high phase
    assign scl_rise   = scl_s & ~scl_q;
    assign scl_fall   = ~scl_s & scl_q;
    assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;
    assign rx_byte    = {shift[6:0], sda_s};

    // byte receiver and protocol sequence
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state     <= WIP_ST_IDLE;
            kind      <= WIP_KIND_ADDR;
            bit_cnt   <= 3'h0;
            shift     <= 8'h00;
            pointer   <= 8'h00;
            data_byte <= 8'h00;
            ack_pend  <= 1'b0;
            drive_low <= 1'b0;
            send_word <= 1'b0;
        end else begin
            send_word <= 1'b0;
            if (start_seen) begin
                // partial byte dropped, address phase again
                state     <= WIP_ST_ADDR;
                bit_cnt   <= 3'h0;
                ack_pend  <= 1'b0;
                drive_low <= 1'b0;
            end else if (stop_seen) begin
                state     <= WIP_ST_IDLE;
                ack_pend  <= 1'b0;
                drive_low <= 1'b0;
            end else begin
                unique case (state)
                    WIP_ST_IDLE, WIP_ST_IGNORE: begin
                        drive_low <= 1'b0;
                    end
                    WIP_ST_ADDR, WIP_ST_REG, WIP_ST_DATA: begin
                        if (scl_rise) begin
                            shift   <= rx_byte;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == WIP_LAST_BIT) begin
                                ack_pend <= 1'b1;
                                if (state == WIP_ST_ADDR) begin
                                    kind <= WIP_KIND_ADDR;
                                    if (rx_byte[7:3] != WIP_ADDR_FIXED
                                        || rx_byte[2:1] != addr_low
                                        || rx_byte[0] != WIP_RW_WRITE) begin
                                        state    <= WIP_ST_IGNORE;
                                        ack_pend <= 1'b0;
                                    end
                                end else if (state == WIP_ST_REG) begin
                                    kind    <= WIP_KIND_REG;
                                    pointer <= rx_byte;
                                end else begin
                                    kind      <= WIP_KIND_DATA;
                                    data_byte <= rx_byte;
                                end
                            end
                        end else if (scl_fall && ack_pend) begin
                            // pull low for the whole ninth pulse
                            ack_pend  <= 1'b0;
                            drive_low <= 1'b1;
                            state     <= WIP_ST_ACK;
                            if (kind == WIP_KIND_DATA) begin
                                send_word <= 1'b1;
                            end
                        end
                    end
                    WIP_ST_ACK: begin
                        if (scl_fall) begin
                            drive_low <= 1'b0;
                            bit_cnt   <= 3'h0;
                            unique case (kind)
                                WIP_KIND_ADDR: state <= WIP_ST_REG;
                                WIP_KIND_REG:  state <= WIP_ST_DATA;
                                WIP_KIND_DATA: begin
                                    state   <= WIP_ST_DATA;
                                    pointer <= pointer + WIP_PTR_STEP;
                                end
                                default:       state <= WIP_ST_IGNORE;
                            endcase
                        end
                    end
                    default: state <= WIP_ST_IDLE;
                endcase
            end
        end
    end

    // open drain: only ever pulls low, SCL never driven
    assign sda_out = WIP_SDA_LOW;
    assign sda_oe  = drive_low;

    wip_word_cross #(
        .WIDTH (2 * WIP_BYTE_BITS)
    ) u_cross (
        .src_clk   (link_clk),
        .src_rst   (link_rst),
        .src_send  (send_word),
        .src_word  ({pointer, data_byte}),
        .dst_clk   (clock),
        .dst_rst   (sys_rst),
        .dst_valid (reg_wr_valid),
        .dst_word  ({reg_wr_addr, reg_wr_data})
    );

    // shutdown pin into the system domain
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sdn_meta      <= 1'b1;
            sdn_s         <= 1'b1;
            chip_shutdown <= 1'b0;
        end else begin
            sdn_meta      <= shutdown_n_pin;
            sdn_s         <= sdn_meta;
            chip_shutdown <= ~sdn_s;
        end
    end
endmodule

// ==== wip_pkg.sv ====
/*
 * Constants and types shared by the write-only two-wire register port.
 * Assumes nothing of its surroundings; imported by the port and its crossing.
 */
package wip_pkg;

    // fixed upper part of the slave address
    localparam logic [4:0] WIP_ADDR_FIXED   = 5'h1B;
    localparam int         WIP_BYTE_BITS    = 8;
    localparam logic [2:0] WIP_LAST_BIT     = 3'h7;
    localparam logic       WIP_RW_WRITE     = 1'b0;
    localparam logic       WIP_SDA_LOW      = 1'b0;
    localparam logic [7:0] WIP_PTR_STEP     = 8'h01;

    // strap pin connection, as seen by the board
    typedef enum logic [1:0] {
        WIP_STRAP_GND = 2'h0,
        WIP_STRAP_VCC = 2'h1,
        WIP_STRAP_SCL = 2'h2,
        WIP_STRAP_SDA = 2'h3
    } wip_strap_t;

    // address bits two and one for each strap connection
    localparam logic [1:0] WIP_AD_GND = 2'h0;
    localparam logic [1:0] WIP_AD_VCC = 2'h3;
    localparam logic [1:0] WIP_AD_SCL = 2'h1;
    localparam logic [1:0] WIP_AD_SDA = 2'h2;

    typedef enum logic [2:0] {
        WIP_ST_IDLE   = 3'h0,
        WIP_ST_ADDR   = 3'h1,
        WIP_ST_REG    = 3'h2,
        WIP_ST_DATA   = 3'h3,
        WIP_ST_ACK    = 3'h4,
        WIP_ST_IGNORE = 3'h5
    } wip_state_t;

    typedef enum logic [1:0] {
        WIP_KIND_ADDR = 2'h0,
        WIP_KIND_REG  = 2'h1,
        WIP_KIND_DATA = 2'h2
    } wip_kind_t;

endpackage

// ==== wip_word_cross.sv ====
/*
 * Toggle-handshake crossing for one word from the link domain to the system domain.
 * Assumes the source holds its word and sends no new one for several destination
 * clocks after each toggle.
 */
`timescale 1ns/1ps
module wip_word_cross import wip_pkg::*; #(
    parameter int WIDTH = 16
) (
    // source side
    input  wire logic             src_clk,
    input  wire logic             src_rst,
    input  wire logic             src_send,
    input  wire logic [WIDTH-1:0] src_word,
    // destination side
    input  wire logic             dst_clk,
    input  wire logic             dst_rst,
    output logic                  dst_valid,
    output logic      [WIDTH-1:0] dst_word
);
    logic             src_toggle;
    logic [WIDTH-1:0] src_hold;
    logic             sync_meta;
    logic             sync_a;
    logic             sync_b;

    initial begin
        if (WIDTH < 1) $error("wip_word_cross: WIDTH must be positive");
    end

    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            src_toggle <= 1'b0;
            src_hold   <= '0;
        end else if (src_send) begin
            src_toggle <= ~src_toggle;
            src_hold   <= src_word;
        end
    end

    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            sync_meta <= 1'b0;
            sync_a    <= 1'b0;
            sync_b    <= 1'b0;
        end else begin
            sync_meta <= src_toggle;
            sync_a    <= sync_meta;
            sync_b    <= sync_a;
        end
    end

    // word is stable long before the toggle edge is seen here
    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            dst_valid <= 1'b0;
            dst_word  <= '0;
        end else begin
            dst_valid <= sync_a ^ sync_b;
            if (sync_a ^ sync_b) begin
                dst_word <= src_hold;
            end
        end
    end
endmodule

// ==== wip_port_monitor.sv ====
/* Pin-level assertions for the write-only register port.
   Assumes SCL phases of several link clocks, as the bench master drives. */
`timescale 1ns/1ps
module wip_port_monitor import wip_pkg::*; (
    // clocks and reset
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       link_clk,
    // bus
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // pins
    input wire logic [1:0] strap_conn,
    input wire logic       shutdown_n_pin,
    // write output
    input wire logic       reg_wr_valid,
    input wire logic [7:0] reg_wr_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic       chip_shutdown
);
    a_pull_low_only:
        assert property (@(posedge link_clk) disable iff (!resetn) sda_oe |-> sda_out == WIP_SDA_LOW)
        else $error("sda driven high");
    a_ack_rise_low:
        assert property (@(posedge link_clk) disable iff (!resetn) $rose(sda_oe) |-> !scl_in)
        else $error("ack starts while scl high");
    a_ack_fall_low:
        assert property (@(posedge link_clk) disable iff (!resetn) $fell(sda_oe) |-> !scl_in)
        else $error("ack ends while scl high");
    a_ack_stands:
        assert property (@(posedge link_clk) disable iff (!resetn) $rose(sda_oe) |-> sda_oe [*8])
        else $error("ack too short");
    a_wr_one_cycle:
        assert property (@(posedge clock) disable iff (!resetn) reg_wr_valid |=> !reg_wr_valid)
        else $error("write pulse too long");
    a_wr_hold:
        assert property (@(posedge clock) disable iff (!resetn)
            !reg_wr_valid |-> $stable(reg_wr_addr) && $stable(reg_wr_data))
        else $error("write fields moved");
    a_shut_on:
        assert property (@(posedge clock) disable iff (!resetn) !shutdown_n_pin [*4] |-> chip_shutdown)
        else $error("shutdown missed");
    a_shut_off:
        assert property (@(posedge clock) disable iff (!resetn) shutdown_n_pin [*4] |-> !chip_shutdown)
        else $error("shutdown stuck");
endmodule

bind wip_port wip_port_monitor u_mon (.*);

// ==== wip_master.sv ====
/* Behavioural bus master facing the register port.
   Assumes a pull-up on SDA, resolved by the bench. */
`timescale 1ns/1ps
module wip_master (
    // bus
    output logic      scl,
    output logic      sda,
    input  wire logic sda_bus
);
    // 2.6 us period, below 400 kHz
    localparam time HALF = 1300ns;
    localparam time QTR  = 650ns;

    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic start();
        sda = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda = 1'b0;
        #HALF scl = 1'b0;
        #QTR;
    endtask

    task automatic stop();
        sda = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda = 1'b1;
        #HALF;
    endtask

    // n below 8 leaves a partial byte, no ack pulse
    task automatic send(input logic [7:0] b, input int n, output logic ack);
        for (int i = 7; i > 7 - n; i--) begin
            sda = b[i];
            #QTR scl = 1'b1;
            #HALF scl = 1'b0;
            #QTR;
        end
        ack = 1'b0;
        if (n == 8) begin
            sda = 1'b1;
            #QTR scl = 1'b1;
            ack = (sda_bus === 1'b0);
            #HALF ack = ack & (sda_bus === 1'b0);
            scl = 1'b0;
            #QTR;
        end
    endtask
endmodule

// ==== wip_port_bench.sv ====
/* Self-checking bench for the write-only register port.
   Assumes the master model and checker compiled beside it. */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module wip_port_bench import wip_pkg::*; ();
    localparam logic [1:0] AD_OF [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        link_clk = 1'b0;
    logic        shutdown_n_pin = 1'b1;
    logic [1:0]  strap_conn = 2'h0;
    logic        scl_m, sda_m, sda_out, sda_oe, reg_wr_valid, chip_shutdown, ack;
    logic [7:0]  reg_wr_addr, reg_wr_data;
    logic [15:0] seen [$];
    int          fails = 0;
    int          num_checks = 0;
    // open-drain wire with pull-up
    wire         sda_bus = sda_m & (sda_oe ? sda_out : 1'b1);

    always #5 clock = ~clock;
    initial #37 forever #80 link_clk = ~link_clk;
    always @(posedge clock) if (reg_wr_valid === 1'b1) seen.push_back({reg_wr_addr, reg_wr_data});

    wip_port DUT (.clock(clock), .resetn(resetn), .link_clk(link_clk), .scl_in(scl_m), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe(sda_oe), .strap_conn(strap_conn), .shutdown_n_pin(shutdown_n_pin),
        .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .chip_shutdown(chip_shutdown));
    wip_master master (.scl(scl_m), .sda(sda_m), .sda_bus(sda_bus));

    task automatic print_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] s);
        @(posedge clock) #1 strap_conn = s;
        resetn = 1'b0;
        repeat (5) @(posedge link_clk);
        @(posedge clock) #1 resetn = 1'b1;
        repeat (12) @(posedge link_clk);
        seen.delete();
    endtask

    task automatic tx(input logic [7:0] b, input logic exp);
        master.send(b, 8, ack);
        `CHK("ack", exp, ack)
    endtask

    task automatic t_strap();
        for (int i = 0; i < 4; i++) begin
            do_reset(2'(i));
            master.start();
            tx({5'h1B, AD_OF[i], 1'b0}, 1'b1);
            master.stop();
        end
    endtask

    task automatic t_burst();
        logic [15:0] exp [3] = '{16'hFFA5, 16'h005A, 16'h01C3};
        do_reset(2'h0);
        master.start();
        tx(8'hD8, 1'b1);
        tx(8'hFF, 1'b1);
        foreach (exp[i]) tx(exp[i][7:0], 1'b1);
        master.stop();
        `CHK("count", 3, seen.size())
        foreach (exp[i]) `CHK("write", exp[i], seen[i])
    endtask

    task automatic t_refuse();
        logic [7:0] bad [3] = '{8'hD9, 8'hDA, 8'h58};
        seen.delete();
        foreach (bad[i]) begin
            master.start();
            tx(bad[i], 1'b0);
            tx(8'h10, 1'b0);
            master.stop();
        end
        `CHK("count", 0, seen.size())
    endtask

    task automatic t_restart();
        seen.delete();
        master.start();
        tx(8'hD8, 1'b1);
        tx(8'h20, 1'b1);
        master.send(8'h99, 4, ack);
        master.start();
        tx(8'hD8, 1'b1);
        tx(8'h21, 1'b1);
        tx(8'h77, 1'b1);
        master.stop();
        `CHK("count", 1, seen.size())
        `CHK("write", 16'h2177, seen[0])
    endtask

    task automatic t_shutdown();
        `CHK("shut", 1'b0, chip_shutdown)
        @(posedge clock) #1 shutdown_n_pin = 1'b0;
        repeat (4) @(posedge clock);
        #1 `CHK("shut", 1'b1, chip_shutdown)
        shutdown_n_pin = 1'b1;
        repeat (4) @(posedge clock);
        #1 `CHK("shut", 1'b0, chip_shutdown)
    endtask

    initial begin
        repeat (3) @(posedge clock);
        t_strap();
        t_burst();
        t_refuse();
        t_restart();
        t_shutdown();
        print_verdict();
    end

    initial begin
        repeat (95000) @(posedge clock);
        fails++;
        print_verdict();
    end
endmodule
